// [core/rsdc_map.vh]
// register map, field layout and reset values of the clock configuration
// Operation
// - enable high: prescaled reference to backplane and phase detector
// - enable low: driver off, backplane input goes to phase detector
// - prescaler divides by 1, 4, 5 or 8; 00 is /4 default, 01 is /5
// - vco equals reference times feedback input and feedback output dividers
// - each output pair divides vco by its own select: 0 is /4, 1 is /5
// - an output divider select left at default gives divide-by-4
// - enable field 01 lets only first and second pairs toggle
// - feedback output divider defaults to 4, feedback input divider to 5
// - backplane driver enable defaults to one, backplane pair is output
`ifndef RSDC_MAP_VH
`define RSDC_MAP_VH

`define RSDC_CTRL_OFS      12'h000
`define RSDC_STAT_OFS      12'h004

`define RSDC_BP_EN_BIT     0
`define RSDC_PRE_LSB       1
`define RSDC_PRE_MSB       2
`define RSDC_QSEL_LSB      4
`define RSDC_QSEL_MSB      7
`define RSDC_OE_LSB        8
`define RSDC_OE_MSB        9
`define RSDC_FBO_LSB       12
`define RSDC_FBO_MSB       15
`define RSDC_FBI_LSB       16
`define RSDC_FBI_MSB       19

`define RSDC_BP_EN_RST     1'b1
`define RSDC_PRE_RST       2'b00
`define RSDC_QSEL_RST      4'h0
`define RSDC_OE_RST        2'b00
`define RSDC_FBO_RST       4'h4
`define RSDC_FBI_RST       4'h5

`define RSDC_PRE_DIV4      2'b00
`define RSDC_PRE_DIV5      2'b01
`define RSDC_PRE_DIV1      2'b10
`define RSDC_PRE_DIV8      2'b11

`define RSDC_OE_ALL        2'b00
`define RSDC_OE_TWO        2'b01
`define RSDC_OE_ONE        2'b10
`define RSDC_OE_NONE       2'b11

`define RSDC_QDIV_LO       4'h4
`define RSDC_QDIV_HI       4'h5

`endif

// [core/rsdc_top.v]
// reference select, prescaler, feedback and output dividers with apb control
`timescale 1ns/1ns
`include "rsdc_map.vh"

// one glitch-free divider stage driven by rising edges of its source
module rsdc_div (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       src_i,
    input  wire       tick_i,
    input  wire [3:0] div_i,
    input  wire       en_i,
    output reg        q_o,
    output reg        rise_o
);
    reg  [3:0] cnt_q;
    reg  [3:0] div_q;
    reg        en_q;
    wire [3:0] div_eff = (div_i == 4'h0) ? 4'h1 : div_i;
    wire       wrap    = (cnt_q >= div_q - 4'h1);
    wire [3:0] cnt_d   = wrap ? 4'h0 : cnt_q + 4'h1;
    // ceil(n/2) without the 4-bit wrap of n+1 at n = 15
    wire [3:0] half    = {1'b0, div_q[3:1]} + {3'b000, div_q[0]};
    wire       q_d     = (div_q == 4'h1) ? src_i : (cnt_d < half);

    // new ratio and enable are taken at the end of a full period, or on every clock while the ratio is 1
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 4'h0;
            div_q  <= 4'h1;
            en_q   <= 1'b0;
            q_o    <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (div_q == 4'h1) begin
                q_o    <= en_q & q_d;
                rise_o <= en_q & q_d & ~q_o;
                div_q  <= div_eff;
                en_q   <= en_i;
            end else if (tick_i) begin
                cnt_q  <= cnt_d;
                q_o    <= en_q & q_d;
                rise_o <= en_q & q_d & ~q_o;
                if (wrap) begin
                    div_q <= div_eff;
                    en_q  <= en_i;
                    q_o   <= en_i;
                    rise_o <= en_i & ~q_o;
                end
            end
        end
    end
endmodule

// top: configuration registers and the clock divider network
module rsdc_top #(
    parameter NUM_OUT = 4
) (
    input  wire               clk_i,
    input  wire               rst_n_i,
    input  wire               psel_i,
    input  wire               penable_i,
    input  wire               pwrite_i,
    input  wire [11:0]        paddr_i,
    input  wire [31:0]        pwdata_i,
    output reg  [31:0]        prdata_o,
    output reg                pready_o,
    output reg                pslverr_o,
    input  wire               local_ref_i,
    input  wire               vco_i,
    input  wire               backplane_p_i,
    output reg                backplane_p_o,
    output reg                backplane_n_o,
    output reg                backplane_oe_o,
    output reg                pd_ref_o,
    output reg                pd_fb_o,
    output reg  [NUM_OUT-1:0] out_pair_p_o,
    output reg  [NUM_OUT-1:0] out_pair_n_o
);
    reg                backplane_driver_enable_q;
    reg  [1:0]         reference_prescaler_select_q;
    reg  [NUM_OUT-1:0] output_divider_select_q;
    reg  [1:0]         output_enable_q;
    reg  [3:0]         feedback_output_divider_q;
    reg  [3:0]         feedback_input_divider_q;
    reg                ref_prev_q;
    reg                vco_prev_q;
    reg  [3:0]         pre_div;
    reg  [NUM_OUT-1:0] pair_en;
    reg  [31:0]        rdata_d;
    reg                err_d;
    wire [31:0]        ctrl_val;
    wire [31:0]        stat_val;
    wire               pre_q;
    wire               pre_rise;
    wire               fbo_q;
    wire               fbo_rise;
    wire               fbi_q;
    wire [NUM_OUT-1:0] pair_q;
    wire               acc = psel_i & penable_i & pready_o;
    wire               ref_tick = local_ref_i & ~ref_prev_q;
    wire               vco_tick = vco_i & ~vco_prev_q;

    // source edge detectors; track the pins in reset, no false edge
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ref_prev_q <= local_ref_i;
            vco_prev_q <= vco_i;
        end else begin
            ref_prev_q <= local_ref_i;
            vco_prev_q <= vco_i;
        end
    end

    // prescaler ratio decode
    always @* begin
        case (reference_prescaler_select_q)
            `RSDC_PRE_DIV4: pre_div = 4'h4;
            `RSDC_PRE_DIV5: pre_div = 4'h5;
            `RSDC_PRE_DIV1: pre_div = 4'h1;
            default:        pre_div = 4'h8;
        endcase
    end

    // output enable field decode
    always @* begin
        pair_en = {NUM_OUT{1'b0}};
        case (output_enable_q)
            `RSDC_OE_ALL: pair_en = {NUM_OUT{1'b1}};
            `RSDC_OE_TWO: pair_en[1:0] = 2'b11;
            `RSDC_OE_ONE: pair_en[0] = 1'b1;
            default:      pair_en = {NUM_OUT{1'b0}};
        endcase
    end

    // local reference prescaler
    rsdc_div u_pre (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .src_i   (local_ref_i),
        .tick_i  (ref_tick),
        .div_i   (pre_div),
        .en_i    (1'b1),
        .q_o     (pre_q),
        .rise_o  (pre_rise)
    );

    // feedback output divider then feedback input divider
    rsdc_div u_fbo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .src_i   (vco_i),
        .tick_i  (vco_tick),
        .div_i   (feedback_output_divider_q),
        .en_i    (1'b1),
        .q_o     (fbo_q),
        .rise_o  (fbo_rise)
    );

    rsdc_div u_fbi (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .src_i   (fbo_q),
        .tick_i  (fbo_rise),
        .div_i   (feedback_input_divider_q),
        .en_i    (1'b1),
        .q_o     (fbi_q),
        .rise_o  ()
    );

    // output pair dividers, /4 or /5 each
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_pair
            rsdc_div u_q (
                .clk_i   (clk_i),
                .rst_n_i (rst_n_i),
                .src_i   (vco_i),
                .tick_i  (vco_tick),
                .div_i   (output_divider_select_q[gi] ?
                          `RSDC_QDIV_HI : `RSDC_QDIV_LO),
                .en_i    (pair_en[gi]),
                .q_o     (pair_q[gi]),
                .rise_o  ()
            );
        end
    endgenerate

    // pins: backplane driver, phase detector inputs, output pairs
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            backplane_p_o  <= 1'b0;
            backplane_n_o  <= 1'b1;
            backplane_oe_o <= 1'b0;
            pd_ref_o       <= 1'b0;
            pd_fb_o        <= 1'b0;
            out_pair_p_o   <= {NUM_OUT{1'b0}};
            out_pair_n_o   <= {NUM_OUT{1'b1}};
        end else begin
            backplane_oe_o <= backplane_driver_enable_q;
            backplane_p_o  <= pre_q;
            backplane_n_o  <= ~pre_q;
            pd_ref_o       <= backplane_driver_enable_q ?
                              pre_q : backplane_p_i;
            pd_fb_o        <= fbi_q;
            out_pair_p_o   <= pair_q;
            out_pair_n_o   <= ~pair_q;
        end
    end

    assign ctrl_val = {12'h000, feedback_input_divider_q,
                       feedback_output_divider_q, 2'b00, output_enable_q,
                       {(4-NUM_OUT){1'b0}}, output_divider_select_q,
                       1'b0, reference_prescaler_select_q,
                       backplane_driver_enable_q};
    assign stat_val = {20'h0_0000, {(4-NUM_OUT){1'b0}}, out_pair_p_o,
                       pair_en, backplane_oe_o, pd_fb_o,
                       pd_ref_o, backplane_p_i};

    // apb read mux and unmapped decode
    always @* begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        if (paddr_i == `RSDC_CTRL_OFS) begin
            rdata_d = ctrl_val;
        end else if (paddr_i == `RSDC_STAT_OFS) begin
            rdata_d = stat_val;
            err_d   = pwrite_i;
        end else begin
            err_d   = 1'b1;
        end
    end

    // apb handshake: one wait state, answer registered
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            prdata_o  <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ?
                         rdata_d : 32'h0000_0000;
            pslverr_o <= psel_i & penable_i & ~pready_o & err_d;
        end
    end

    // control register, defaults match unstrapped pins
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            backplane_driver_enable_q    <= `RSDC_BP_EN_RST;
            reference_prescaler_select_q <= `RSDC_PRE_RST;
            output_divider_select_q      <= `RSDC_QSEL_RST;
            output_enable_q              <= `RSDC_OE_RST;
            feedback_output_divider_q    <= `RSDC_FBO_RST;
            feedback_input_divider_q     <= `RSDC_FBI_RST;
        end else if (acc & pwrite_i & (paddr_i == `RSDC_CTRL_OFS)) begin
            backplane_driver_enable_q    <= pwdata_i[`RSDC_BP_EN_BIT];
            reference_prescaler_select_q <=
                pwdata_i[`RSDC_PRE_MSB:`RSDC_PRE_LSB];
            output_divider_select_q      <=
                pwdata_i[`RSDC_QSEL_LSB+NUM_OUT-1:`RSDC_QSEL_LSB];
            output_enable_q              <=
                pwdata_i[`RSDC_OE_MSB:`RSDC_OE_LSB];
            feedback_output_divider_q    <=
                pwdata_i[`RSDC_FBO_MSB:`RSDC_FBO_LSB];
            feedback_input_divider_q     <=
                pwdata_i[`RSDC_FBI_MSB:`RSDC_FBI_LSB];
        end
    end
endmodule

// [sim/rsdc_props.sv]
// checker for apb timing and clock pair outputs
`timescale 1ns/1ns
module rsdc_props #(
    parameter NUM_OUT = 4
) (
    input wire               clk_i,
    input wire               rst_n_i,
    input wire               psel_i,
    input wire               penable_i,
    input wire [31:0]        prdata_o,
    input wire               pready_o,
    input wire               pslverr_o,
    input wire               backplane_p_i,
    input wire               backplane_p_o,
    input wire               backplane_n_o,
    input wire               backplane_oe_o,
    input wire               pd_ref_o,
    input wire [NUM_OUT-1:0] out_pair_p_o,
    input wire [NUM_OUT-1:0] out_pair_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // setup cycle followed by the first access cycle
    sequence s_xfer;
        psel_i && !penable_i ##1 psel_i && penable_i;
    endsequence

    a_ready_wait: assert property (s_xfer |=> pready_o)
        else $error("ready missing one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_read_zero: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data outside ready cycle");
    a_pair_inverse: assert property (out_pair_n_o == ~out_pair_p_o)
        else $error("pair legs not inverse");
    a_bp_inverse: assert property (backplane_n_o == !backplane_p_o)
        else $error("backplane legs not inverse");
    a_pd_local: assert property (
        backplane_oe_o && $past(backplane_oe_o) |-> pd_ref_o == backplane_p_o)
        else $error("phase reference differs from driven clock");
    a_pd_follow: assert property (
        !backplane_oe_o && !$past(backplane_oe_o) && $past(rst_n_i, 3)
        |-> pd_ref_o == $past(backplane_p_i))
        else $error("phase reference not following backplane input");
endmodule

bind rsdc_top rsdc_props #(.NUM_OUT(NUM_OUT)) i_rsdc_props (.clk_i, .rst_n_i,
    .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .backplane_p_i,
    .backplane_p_o, .backplane_n_o, .backplane_oe_o, .pd_ref_o,
    .out_pair_p_o, .out_pair_n_o);

// [sim/rsdc_src.sv]
// square wave source standing in for a reference, vco or backplane clock
`timescale 1ns/1ns
module rsdc_src (
    input  wire       clk_i,
    input  wire [3:0] half_i,
    output reg        clk_o
);
    reg [3:0] cnt_q;
    initial begin
        clk_o = 1'b0;
        cnt_q = 4'h0;
    end
    // toggle every half_i cycles, zero holds the level still
    always @(posedge clk_i) begin
        if (half_i != 4'h0 && cnt_q + 4'h1 >= half_i) begin
            cnt_q <= 4'h0;
            clk_o <= ~clk_o;
        end else if (half_i != 4'h0) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// [sim/test_rsdc_top.sv]
// self-checking bench for the clock configuration block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
    compares = compares + 1; \
    if ((got) !== (ex)) begin \
        n_mismatch = n_mismatch + 1; \
        $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
end
module test_rsdc_top;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg         psel_i = 1'b0;
    reg         penable_i = 1'b0;
    reg         pwrite_i = 1'b0;
    reg  [11:0] paddr_i = 12'h000;
    reg  [31:0] pwdata_i = 32'h0000_0000;
    wire [31:0] prdata_o;
    wire        pready_o, pslverr_o, lref, vco, bp_in, bp_p, bp_oe;
    wire        pd_ref, pd_fb;
    wire [3:0]  op;
    integer     compares = 0;
    integer     n_mismatch = 0;
    integer     pre_tab [0:3] = '{16, 20, 4, 32};
    integer     c;
    reg  [31:0] rd;
    reg         er;
    wire [7:0]  mon = {pd_fb, pd_ref, bp_p, 1'b0, op};

    rsdc_top i_rsdc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .local_ref_i(lref), .vco_i(vco),
        .backplane_p_i(bp_in), .backplane_p_o(bp_p), .backplane_n_o(),
        .backplane_oe_o(bp_oe), .pd_ref_o(pd_ref), .pd_fb_o(pd_fb),
        .out_pair_p_o(op), .out_pair_n_o());
    rsdc_src i_ref_src (.clk_i(clk_i), .half_i(4'h2), .clk_o(lref));
    rsdc_src i_vco_src (.clk_i(clk_i), .half_i(4'h2), .clk_o(vco));
    rsdc_src i_bp_src (.clk_i(clk_i), .half_i(4'h3), .clk_o(bp_in));

    initial forever #20 clk_i = ~clk_i;

    // one apb transfer, held until ready is seen at an edge
    task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
        begin
            @(posedge clk_i);
            psel_i <= 1'b1;
            pwrite_i <= wr;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clk_i);
            penable_i <= 1'b1;
            @(posedge clk_i);
            // pready_o ends this wait; the watchdog stops the run if ready never comes
            while (pready_o !== 1'b1)
                @(posedge clk_i);
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask

    // period in clocks between the last two rises of a monitored output
    task per(input integer i, input integer ex, input string nm);
        integer k, last, p;
        reg old;
        begin
            repeat (200) @(posedge clk_i);
            last = -1;
            p = 0;
            old = mon[i];
            for (k = 0; k < 400; k = k + 1) begin
                @(posedge clk_i);
                if (mon[i] === 1'b1 && old !== 1'b1) begin
                    if (last >= 0) p = k - last;
                    last = k;
                end
                old = mon[i];
            end
            `CHK(nm, ex, p)
        end
    endtask

    task t_defaults;
        begin
            apb(1'b0, 12'h000, 32'h0000_0000);
            `CHK("ctrl", 32'h0005_4001, rd)
            `CHK("drv_en", 1'b1, bp_oe)
            per(6, 16, "pd_ref");
            per(5, 16, "bp_out");
            per(7, 80, "pd_fb");
            per(0, 16, "pair0");
        end
    endtask

    task t_prescale;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                apb(1'b1, 12'h000, 32'h0005_4001 | (c << 1));
                per(6, pre_tab[c], "pd_ref");
                per(5, pre_tab[c], "bp_out");
            end
        end
    endtask

    task t_pairs;
        begin
            apb(1'b1, 12'h000, 32'h0005_4121);
            per(0, 16, "pair0");
            per(1, 20, "pair1");
            per(2, 0, "pair2");
            per(3, 0, "pair3");
            `CHK("pair_off", 2'b00, op[3:2])
            apb(1'b0, 12'h004, 32'h0000_0000);
            `CHK("stat_en", 5'h07, rd[7:3])
            `CHK("stat_off", 22'h00_0000, rd[31:10])
            apb(1'b1, 12'h000, 32'h0005_4221);
            per(0, 16, "pair0_one");
            per(1, 0, "pair1_off");
            apb(1'b1, 12'h000, 32'h0005_4321);
            per(0, 0, "pair0_off");
            `CHK("pairs_low", 4'h0, op)
        end
    endtask

    task t_input;
        begin
            apb(1'b1, 12'h000, 32'h0003_2000);
            per(6, 6, "pd_ref");
            per(7, 24, "pd_fb");
            `CHK("drv_en", 1'b0, bp_oe)
        end
    endtask

    task t_err;
        begin
            apb(1'b0, 12'h008, 32'h0000_0000);
            `CHK("unmapped_err", 1'b1, er)
            `CHK("unmapped_data", 32'h0000_0000, rd)
            apb(1'b1, 12'h004, 32'hffff_ffff);
            `CHK("ro_err", 1'b1, er)
        end
    endtask

    task give_verdict;
        begin
            $display("compares %0d n_mismatch %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    initial begin
        #(40 * 30000);
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_defaults;
        t_prescale;
        t_pairs;
        t_input;
        t_err;
        give_verdict;
    end
endmodule
